// ---- dsp_pkg.sv ----
// dsp_pkg: constants, register offsets and types for the data stream prefetcher
// assumes a 32-bit ahb-lite register bus and 128-byte cache lines
package dsp_pkg;

  // -----------------------------------------------------------------------
  // geometry
  // -----------------------------------------------------------------------
  localparam int NUM_STREAMS   = 8;
  localparam int IDX_W         = 3;
  localparam int LINE_W        = 25;
  localparam int MAX_INFLIGHT  = 4;
  localparam int CONF_W        = 2;
  localparam int CNT_W         = 16;

  // -----------------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_SWCMD_OFS  = 8'h04;
  localparam logic [7:0] REG_STATUS_OFS = 8'h08;
  localparam logic [7:0] REG_FEEDBK_OFS = 8'h0c;
  localparam logic [7:0] REG_ID_OFS     = 8'h10;

  // stream_control_register fields
  localparam int URG_LSB   = 0;
  localparam int DEPTH_LSB = 3;
  localparam int SMT_LSB   = 6;
  localparam int STRN_BIT  = 8;

  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0104;
  localparam logic [31:0] ID_VALUE   = 32'h0000_5a01; // arbitrary value

  // urgency levels
  localparam logic [2:0] URG_CONSERV = 3'h1;
  localparam logic [2:0] URG_MAXAGG  = 3'h7;

  // touch hints
  localparam logic [3:0] TH_SINGLE  = 4'h0;
  localparam logic [3:0] TH_START_A = 4'h8;
  localparam logic [3:0] TH_START_B = 4'hb;
  localparam logic [3:0] TH_STOP    = 4'ha;

  // depth bounds in lines
  localparam logic [4:0] DEPTH_MIN  = 5'h04;
  localparam logic [4:0] DEPTH_MAX  = 5'h18;
  localparam logic [2:0] LOOKA_MAX  = 3'h4;

  // adaptive state
  typedef enum logic [1:0] {
    ADP_CONSERV,
    ADP_NORMAL,
    ADP_AGGR
  } dsp_adp_e;

  typedef struct packed {
    logic              valid;
    logic              sw;
    logic              down;
    logic              transient;
    logic              unlimited;
    logic [LINE_W-1:0] next_line;
    logic [4:0]        ahead;
    logic [CNT_W-1:0]  units;
    logic [1:0]        conf;
    logic [IDX_W-1:0]  age;
  } dsp_entry_s;

endpackage

// ---- dsp_issue_ring.sv ----
// dsp_issue_ring: tracks prefetches in flight and grants new issues
// assumes the memory side returns one done pulse per issued request
`timescale 1ns/1ps
module dsp_issue_ring
  import dsp_pkg::*;
(
  input  wire logic MCLK,
  input  wire logic RESET_N,
  input  wire logic issue,
  input  wire logic done,
  output logic      can_issue,
  output logic [2:0] inflight
);

  typedef struct packed {
    logic [2:0] cnt;
  } dsp_ring_s;

  dsp_ring_s st_q;
  dsp_ring_s st_d;

  assign can_issue = (st_q.cnt < 3'(MAX_INFLIGHT));
  assign inflight  = st_q.cnt;

  always_comb begin
    st_d = st_q;
    if ((issue && can_issue) && !(done && st_q.cnt != 3'h0)) begin
      st_d.cnt = st_q.cnt + 3'h1;
    end else if (!(issue && can_issue) && done && st_q.cnt != 3'h0) begin
      st_d.cnt = st_q.cnt - 3'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ---- dsp_prefetcher.sv ----
// dsp_prefetcher: stream-tracking queue, allocation, confirm, prefetch issue
// Function
// - at most eight streams tracked, one stream_tracking_queue entry each
// - unmatched L1 load miss allocates entry holding next predicted line
// - access matching next predicted line confirms and advances entry
// - new streams ascend; seeing opposite neighbour flips direction, repeatably
// - start-up burst size follows urgency and adaptive state
// - each steady confirm issues one L1/L2 line (every second confirm in aggressive mode), plus one L3 line while confidence is below 3
// - prefetch takes one load/store pipe for exactly one cycle
// - prefetch hitting L1 is discarded, nothing sent to memory
// - L1 prefetch goes to load_miss_queue; L3 over translate port
// - fully pipelined, up to four prefetches in flight
// - every request carries a confidence level; controller may drop low ones
// - controller feedback adjusts ramp and lookahead depth
// - urgency 1 forces conservative mode; urgency 7 never conservative
// - initial lookahead zero to four lines by urgency and adaptive state
// - maximum run-ahead depth 4 to 24 lines by depth field, smt mode
// - touch hint 0 fetches one L1 line; touch-for-store one L3 line
// - hints 8, b, a start or stop software L1 streams in entries
// - software streams finite or unlimited; unlimited live until stop hint or context switch
// - new software stream prefetches until depth or unit count reached
// - software stream becomes hardware on switch, stop, or count reached
// - transient flag marks requests for easy L3 replacement
// assumes one access per cycle from the load/store slices and ahb-lite registers
`timescale 1ns/1ps
module dsp_prefetcher
  import dsp_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              RESET_N,
  // ahb-lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic [31:0]            HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // accesses from load/store slices
  input  wire logic              ACC_VALID,
  input  wire logic [LINE_W-1:0] ACC_LINE,
  input  wire logic              ACC_IS_LOAD,
  input  wire logic              ACC_L1_MISS,
  // software touch operations
  input  wire logic              TOUCH_VALID,
  input  wire logic              TOUCH_STORE,
  input  wire logic [3:0]        TOUCH_HINT,
  input  wire logic [LINE_W-1:0] TOUCH_LINE,
  input  wire logic [CNT_W-1:0]  TOUCH_UNITS,
  input  wire logic              TOUCH_DOWN,
  input  wire logic              TOUCH_TRANSIENT,
  input  wire logic              CTX_SWITCH,
  // pipe slot and l1 lookup
  input  wire logic              PIPE_GRANT,
  output logic                   PIPE_REQ,
  output logic [LINE_W-1:0]      PIPE_LINE,
  input  wire logic              PIPE_L1_HIT,
  // memory side
  output logic                   LMQ_VALID,
  output logic [LINE_W-1:0]      LMQ_LINE,
  output logic [CONF_W-1:0]      LMQ_CONF,
  output logic                   L3_VALID,
  output logic [LINE_W-1:0]      L3_LINE,
  output logic [CONF_W-1:0]      L3_CONF,
  output logic                   L3_TRANSIENT,
  input  wire logic              MEM_DONE,
  input  wire logic              MEM_FB_VALID,
  input  wire logic              MEM_FB_BUSY
);

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  typedef struct packed {
    dsp_entry_s [NUM_STREAMS-1:0] ent;
    logic [31:0]       ctrl;
    dsp_adp_e          adp;
    logic [3:0]        fb_cnt;
    logic              dph;
    logic              dph_wr;
    logic [7:0]        dph_addr;
    logic              pend;
    logic              pend_l3;
    logic [LINE_W-1:0] pend_line;
    logic [CONF_W-1:0] pend_conf;
    logic              pend_tr;
    logic              pend_strm;
    logic              chk;
    logic              chk_l3;
    logic [LINE_W-1:0] chk_line;
    logic [CONF_W-1:0] chk_conf;
    logic              chk_tr;
    logic              lmq_v;
    logic              l3_v;
    logic [LINE_W-1:0] out_line;
    logic [CONF_W-1:0] out_conf;
    logic              out_tr;
    logic [31:0]       rdata;
    logic [IDX_W-1:0]  sel;
  } dsp_state_s;

  dsp_state_s st_q;
  dsp_state_s st_d;

  logic       can_issue;
  logic [2:0] inflight;
  logic       issue_go;

  dsp_issue_ring u_ring (
    .MCLK      (MCLK),
    .RESET_N   (RESET_N),
    .issue     (issue_go),
    .done      (MEM_DONE),
    .can_issue (can_issue),
    .inflight  (inflight)
  );

  // -----------------------------------------------------------------------
  // match, direction, victim search
  // -----------------------------------------------------------------------
  logic [NUM_STREAMS-1:0] hit_fwd;
  logic [NUM_STREAMS-1:0] hit_rev;
  logic [NUM_STREAMS-1:0] free_v;
  logic [NUM_STREAMS-1:0] hw_v;
  logic [NUM_STREAMS-1:0] want_v;
  logic [4:0]             max_depth;
  logic [4:0]             depth_raw;
  logic [2:0]             urgency_field;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_STREAMS; gi++) begin : g_match
      logic [LINE_W-1:0] prev2;
      // reverse: opposite neighbour is two lines back from predicted
      assign prev2 = st_q.ent[gi].down ? st_q.ent[gi].next_line + LINE_W'(2)
                                       : st_q.ent[gi].next_line - LINE_W'(2);
      assign hit_fwd[gi] = st_q.ent[gi].valid && (st_q.ent[gi].next_line == ACC_LINE);
      assign hit_rev[gi] = st_q.ent[gi].valid && (prev2 == ACC_LINE);
      assign free_v[gi]  = !st_q.ent[gi].valid;
      assign hw_v[gi]    = st_q.ent[gi].valid && !st_q.ent[gi].sw;
      assign want_v[gi]  = st_q.ent[gi].valid && (st_q.ent[gi].ahead < max_depth);
    end
  endgenerate

  assign urgency_field       = st_q.ctrl[URG_LSB +: 3];
  // 4 plus three times depth field 0..7, minus 4 in smt mode above 8, clamped to 24 outside smt mode
  assign depth_raw = 5'(DEPTH_MIN + {st_q.ctrl[DEPTH_LSB +: 3], 1'b0} + 5'(st_q.ctrl[DEPTH_LSB +: 3]));
  assign max_depth = (st_q.ctrl[SMT_LSB +: 2] != 2'h0 && depth_raw > 5'h08) ? 5'(depth_raw - 5'h04)
                   : (depth_raw > DEPTH_MAX ? DEPTH_MAX : depth_raw);

  function automatic logic [IDX_W-1:0] first_of(input logic [NUM_STREAMS-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = NUM_STREAMS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [IDX_W-1:0] oldest_hw(input dsp_entry_s [NUM_STREAMS-1:0] e,
                                                 input logic [NUM_STREAMS-1:0] v);
    logic [IDX_W-1:0] r;
    logic [IDX_W-1:0] best;
    r    = '0;
    best = '0;
    for (int i = 0; i < NUM_STREAMS; i++) begin
      if (v[i] && e[i].age >= best) begin
        best = e[i].age;
        r    = IDX_W'(i);
      end
    end
    return r;
  endfunction

  // -----------------------------------------------------------------------
  // main next-state
  // -----------------------------------------------------------------------
  logic             acc_hit;
  logic [IDX_W-1:0] tgt;
  logic             do_alloc;
  logic [2:0]       init_look;
  logic [1:0]       ramp;
  dsp_entry_s       pick_e;

  always_comb begin
    st_d      = st_q;
    acc_hit   = 1'b0;
    tgt       = '0;
    do_alloc  = 1'b0;
    init_look = 3'h0;
    ramp      = 2'h1;
    issue_go  = 1'b0;
    pick_e    = st_q.ent[first_of(want_v)];

    // adaptive mode from feedback and urgency
    if (MEM_FB_VALID) begin
      st_d.fb_cnt = MEM_FB_BUSY ? ((st_q.fb_cnt == 4'hf) ? st_q.fb_cnt : 4'(st_q.fb_cnt + 4'h1))
                                : ((st_q.fb_cnt == 4'h0) ? st_q.fb_cnt : 4'(st_q.fb_cnt - 4'h1));
    end
    if (urgency_field == URG_CONSERV) begin
      st_d.adp = ADP_CONSERV;
    end else if (st_q.fb_cnt > 4'hb && urgency_field != URG_MAXAGG) begin
      st_d.adp = ADP_CONSERV;
    end else if (st_q.fb_cnt < 4'h4) begin
      st_d.adp = ADP_AGGR;
    end else begin
      st_d.adp = ADP_NORMAL;
    end

    // ramp and initial lookahead
    case (st_q.adp)
      ADP_CONSERV: begin
        init_look = 3'h0;
        ramp      = 2'h1;
      end
      ADP_NORMAL: begin
        init_look = 3'(urgency_field[2:1]);
        ramp      = 2'h1;
      end
      ADP_AGGR: begin
        init_look = (urgency_field >= 3'h4) ? LOOKA_MAX : 3'(urgency_field[2:1] + 2'h1);
        ramp      = 2'h2;
      end
      default: begin
        init_look = 3'h0;
        ramp      = 2'h1;
      end
    endcase

    // aging
    if (ACC_VALID) begin
      for (int i = 0; i < NUM_STREAMS; i++) begin
        if (st_q.ent[i].valid && st_q.ent[i].age != 3'h7) begin
          st_d.ent[i].age = 3'(st_q.ent[i].age + 3'h1);
        end
      end
    end

    // confirm, reverse, allocate
    if (ACC_VALID && st_q.ctrl[STRN_BIT]) begin
      if (|hit_fwd) begin
        acc_hit = 1'b1;
        tgt     = first_of(hit_fwd);
        st_d.ent[tgt].next_line = st_q.ent[tgt].down ? 25'(ACC_LINE - 25'h1) : 25'(ACC_LINE + 25'h1);
        st_d.ent[tgt].age       = '0;
        st_d.ent[tgt].ahead     = (st_q.ent[tgt].ahead > 5'h0) ? 5'(st_q.ent[tgt].ahead - 5'h1) : 5'h0;
        if (st_q.ent[tgt].conf != 2'h3) begin
          st_d.ent[tgt].conf = 2'(st_q.ent[tgt].conf + 2'h1);
        end
      end else if (|hit_rev) begin
        acc_hit = 1'b1;
        tgt     = first_of(hit_rev);
        st_d.ent[tgt].down      = !st_q.ent[tgt].down;
        st_d.ent[tgt].next_line = st_q.ent[tgt].down ? 25'(ACC_LINE + 25'h1) : 25'(ACC_LINE - 25'h1);
        st_d.ent[tgt].ahead     = '0;
        st_d.ent[tgt].age       = '0;
      end else if (ACC_IS_LOAD && ACC_L1_MISS) begin
        do_alloc = 1'b1;
        tgt = (|free_v) ? first_of(free_v) : oldest_hw(st_q.ent, hw_v);
        if ((|free_v) || (|hw_v)) begin
          st_d.ent[tgt]           = '0;
          st_d.ent[tgt].valid     = 1'b1;
          st_d.ent[tgt].next_line = 25'(ACC_LINE + 25'h1);
          st_d.ent[tgt].ahead     = 5'(max_depth - 5'(init_look));
          st_d.ent[tgt].conf      = (st_q.adp == ADP_AGGR) ? 2'h1 : 2'h0;
        end
      end
    end

    // software touch streams
    if (TOUCH_VALID) begin
      if (TOUCH_HINT == TH_START_A || TOUCH_HINT == TH_START_B) begin
        tgt = (|free_v) ? first_of(free_v) : oldest_hw(st_q.ent, hw_v);
        if ((|free_v) || (|hw_v)) begin
          st_d.ent[tgt]           = '0;
          st_d.ent[tgt].valid     = 1'b1;
          st_d.ent[tgt].sw        = 1'b1;
          st_d.ent[tgt].down      = TOUCH_DOWN;
          st_d.ent[tgt].transient = TOUCH_TRANSIENT;
          st_d.ent[tgt].unlimited = (TOUCH_UNITS == '0);
          st_d.ent[tgt].units     = TOUCH_UNITS;
          st_d.ent[tgt].next_line = TOUCH_LINE;
          st_d.ent[tgt].conf      = 2'h3;
        end
      end else if (TOUCH_HINT == TH_STOP) begin
        for (int i = 0; i < NUM_STREAMS; i++) begin
          if (st_q.ent[i].sw) begin
            st_d.ent[i].sw = 1'b0;
          end
        end
      end
    end
    if (CTX_SWITCH) begin
      for (int i = 0; i < NUM_STREAMS; i++) begin
        st_d.ent[i].sw = 1'b0;
      end
    end

    // pick a stream to advance: single touch has priority
    if (!st_q.pend) begin
      if (TOUCH_VALID && TOUCH_HINT == TH_SINGLE) begin
        st_d.pend      = 1'b1;
        st_d.pend_l3   = TOUCH_STORE;
        st_d.pend_line = TOUCH_LINE;
        st_d.pend_conf = 2'h3;
        st_d.pend_tr   = TOUCH_TRANSIENT;
        st_d.pend_strm = 1'b0;
      end else if (|want_v) begin
        st_d.sel = first_of(want_v);
        // start-up burst steps ahead up to max depth, every line at ramp 1, every second line at ramp 2
        st_d.pend      = 1'b1;
        st_d.pend_strm = 1'b1;
        st_d.pend_l3   = 1'b0;
        st_d.pend_line = pick_e.down ? 25'(pick_e.next_line - 25'(pick_e.ahead))
                                     : 25'(pick_e.next_line + 25'(pick_e.ahead));
        st_d.pend_conf = pick_e.conf;
        st_d.pend_tr   = pick_e.transient;
      end
    end

    // issue into load/store pipe, one cycle
    PIPE_REQ  = st_q.pend && can_issue && !(st_q.chk && inflight == 3'(MAX_INFLIGHT - 1));
    PIPE_LINE = st_q.pend_line;
    st_d.chk  = 1'b0;
    if (PIPE_REQ && PIPE_GRANT) begin
      st_d.pend     = 1'b0;
      st_d.chk      = 1'b1;
      st_d.chk_l3   = st_q.pend_l3;
      st_d.chk_line = st_q.pend_line;
      st_d.chk_conf = st_q.pend_conf;
      st_d.chk_tr   = st_q.pend_tr;
      // confidence below 3: l1 line followed by l3 line
      if (!st_q.pend_l3 && st_q.pend_conf != 2'h3) begin
        st_d.pend      = 1'b1;
        st_d.pend_l3   = 1'b1;
        st_d.pend_line = st_q.pend_line;
      end
      if (!st_q.pend_l3 && st_q.pend_strm) begin
        st_d.ent[st_q.sel].ahead = st_q.ent[st_q.sel].sw ? 5'(st_q.ent[st_q.sel].ahead + 5'h1)
                                                         : 5'(st_q.ent[st_q.sel].ahead + 5'(ramp));
        if (st_q.ent[st_q.sel].sw && !st_q.ent[st_q.sel].unlimited) begin
          st_d.ent[st_q.sel].units = CNT_W'(st_q.ent[st_q.sel].units - 16'h1);
          if (st_q.ent[st_q.sel].units == 16'h1) begin
            st_d.ent[st_q.sel].sw    = 1'b0;
            st_d.ent[st_q.sel].ahead = max_depth;
          end
        end
      end
    end

    // l1 lookup result
    st_d.lmq_v = st_q.chk && !PIPE_L1_HIT && !st_q.chk_l3;
    st_d.l3_v  = st_q.chk && !PIPE_L1_HIT && st_q.chk_l3;
    issue_go   = st_d.lmq_v || st_d.l3_v;
    if (st_q.chk) begin
      st_d.out_line = st_q.chk_line;
      st_d.out_conf = st_q.chk_conf;
      st_d.out_tr   = st_q.chk_tr;
    end

    // ahb-lite data phase
    st_d.dph = HSEL && HREADY && HTRANS[1];
    if (HSEL && HREADY) begin
      st_d.dph_wr   = HWRITE;
      st_d.dph_addr = HADDR[7:0];
    end
    if (st_q.dph && st_q.dph_wr && st_q.dph_addr == REG_CTRL_OFS) begin
      st_d.ctrl = HWDATA;
    end
    st_d.rdata = 32'h0;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        REG_CTRL_OFS:   st_d.rdata = st_q.ctrl;
        REG_STATUS_OFS: st_d.rdata = {21'h0, inflight, 6'h0, st_q.adp};
        REG_FEEDBK_OFS: st_d.rdata = {27'h0, max_depth};
        REG_SWCMD_OFS:  begin
          for (int i = 0; i < NUM_STREAMS; i++) begin
            st_d.rdata[i]     = st_q.ent[i].valid;
            st_d.rdata[8 + i] = st_q.ent[i].sw;
          end
        end
        REG_ID_OFS:     st_d.rdata = ID_VALUE;
        default:        st_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q      <= '0;
      st_q.ctrl <= CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  assign HRDATA       = st_q.rdata;
  assign HREADYOUT    = 1'b1;
  assign HRESP        = 1'b0;
  assign LMQ_VALID    = st_q.lmq_v;
  assign LMQ_LINE     = st_q.out_line;
  assign LMQ_CONF     = st_q.out_conf;
  assign L3_VALID     = st_q.l3_v;
  assign L3_LINE      = st_q.out_line;
  assign L3_CONF      = st_q.out_conf;
  assign L3_TRANSIENT = st_q.out_tr;

endmodule

// ---- dsp_props.sv ----
// dsp_props: port checker for the prefetch engine
// assumes bind onto dsp_prefetcher, one clock, async low reset
`timescale 1ns/1ps
module dsp_props
  import dsp_pkg::*;
(
  input wire logic              MCLK,
  input wire logic              RESET_N,
  input wire logic              HSEL,
  input wire logic [31:0]       HADDR,
  input wire logic [1:0]        HTRANS,
  input wire logic              HWRITE,
  input wire logic              HREADY,
  input wire logic [31:0]       HRDATA,
  input wire logic              PIPE_REQ,
  input wire logic              PIPE_GRANT,
  input wire logic [LINE_W-1:0] PIPE_LINE,
  input wire logic              PIPE_L1_HIT,
  input wire logic              LMQ_VALID,
  input wire logic [LINE_W-1:0] LMQ_LINE,
  input wire logic              L3_VALID,
  input wire logic [LINE_W-1:0] L3_LINE,
  input wire logic              MEM_DONE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  logic [3:0] fly_q;
  logic [3:0] fly_d;
  logic       rd_go;
  assign rd_go = HSEL && HREADY && HTRANS[1] && !HWRITE;
  always_comb fly_d = fly_q + 4'(LMQ_VALID) + 4'(L3_VALID) - 4'(MEM_DONE);
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) fly_q <= 4'h0;
    else fly_q <= fly_d;
  end
  id_read_a: assert property (rd_go && HADDR[7:0] == REG_ID_OFS |=> HRDATA == ID_VALUE)
    else $error("id register read wrong");
  unmapped_read_a: assert property (rd_go && HADDR[7:0] > 8'h10 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  issue_out_a: assert property (PIPE_REQ && PIPE_GRANT ##1 !PIPE_L1_HIT |=> LMQ_VALID || L3_VALID)
    else $error("granted prefetch not sent");
  hit_drop_a: assert property (PIPE_REQ && PIPE_GRANT ##1 PIPE_L1_HIT |=> !LMQ_VALID && !L3_VALID)
    else $error("l1 hit prefetch sent");
  send_cause_a: assert property (LMQ_VALID || L3_VALID |-> $past(PIPE_REQ && PIPE_GRANT, 2))
    else $error("request without pipe slot");
  lmq_line_a: assert property (LMQ_VALID |-> LMQ_LINE == $past(PIPE_LINE, 2))
    else $error("load miss queue line wrong");
  l3_line_a: assert property (L3_VALID |-> L3_LINE == $past(PIPE_LINE, 2))
    else $error("l3 line wrong");
  inflight_cap_a: assert property (fly_q <= 4'(MAX_INFLIGHT))
    else $error("too many prefetches in flight");
endmodule

// ---- dsp_mem_model.sv ----
// dsp_mem_model: pipe slot and memory side stand-in
// assumes one done per request; slow mode grants every other cycle
`timescale 1ns/1ps
module dsp_mem_model (
  input  wire logic MCLK,
  input  wire logic RESET_N,
  input  wire logic PIPE_REQ,
  input  wire logic LMQ_VALID,
  input  wire logic L3_VALID,
  input  wire logic hit_mode,
  input  wire logic slow,
  output logic      PIPE_GRANT,
  output logic      PIPE_L1_HIT,
  output logic      MEM_DONE,
  output logic      MEM_FB_VALID,
  output logic      MEM_FB_BUSY
);
  logic [3:0] pend_q;
  logic [3:0] tick_q;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_q <= 4'h0;
      tick_q <= 4'h0;
      PIPE_GRANT <= 1'b0;
      PIPE_L1_HIT <= 1'b0;
      MEM_DONE <= 1'b0;
      MEM_FB_VALID <= 1'b0;
      MEM_FB_BUSY <= 1'b0;
    end else begin
      tick_q <= tick_q + 4'h1;
      PIPE_GRANT <= !slow || !PIPE_GRANT;
      PIPE_L1_HIT <= (PIPE_REQ && PIPE_GRANT) ? hit_mode : tick_q[0];
      pend_q <= pend_q + 4'(LMQ_VALID) + 4'(L3_VALID) - 4'(MEM_DONE);
      MEM_DONE <= (pend_q != 4'(MEM_DONE)) && (!slow || tick_q[1]);
      MEM_FB_VALID <= tick_q == 4'hf;
      MEM_FB_BUSY <= slow;
    end
  end
endmodule

// ---- data_stream_prefetcher_tb.sv ----
// data_stream_prefetcher_tb: register, stream and touch tests
// assumes dsp_mem_model on the memory side, dsp_props bound below
`timescale 1ns/1ps
module data_stream_prefetcher_tb;
  import dsp_pkg::*;
  logic MCLK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0, ACC_VALID = 0, ACC_IS_LOAD = 0, ACC_L1_MISS = 0;
  logic TOUCH_VALID = 0, TOUCH_STORE = 0, TOUCH_TRANSIENT = 0, CTX_SWITCH = 0, hit_mode = 0, slow = 0;
  logic [1:0] HTRANS = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd;
  logic [3:0] TOUCH_HINT = 0;
  logic [CNT_W-1:0] TOUCH_UNITS = 0;
  logic [LINE_W-1:0] ACC_LINE = 0, TOUCH_LINE = 0, PIPE_LINE, LMQ_LINE, L3_LINE, lo, hi;
  logic HREADYOUT, HRESP, PIPE_REQ, PIPE_GRANT, PIPE_L1_HIT, LMQ_VALID, L3_VALID, L3_TRANSIENT;
  logic MEM_DONE, MEM_FB_VALID, MEM_FB_BUSY, l3_tr;
  logic [CONF_W-1:0] LMQ_CONF, L3_CONF;
  int mismatches = 0, total_checks = 0, n1 = 0, n3 = 0;
  always #4 MCLK = ~MCLK;
  dsp_prefetcher i_dut (.MCLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .ACC_VALID, .ACC_LINE, .ACC_IS_LOAD, .ACC_L1_MISS,
    .TOUCH_VALID, .TOUCH_STORE, .TOUCH_HINT, .TOUCH_LINE, .TOUCH_UNITS, .TOUCH_DOWN(1'b0), .TOUCH_TRANSIENT,
    .CTX_SWITCH, .PIPE_GRANT, .PIPE_REQ, .PIPE_LINE, .PIPE_L1_HIT, .LMQ_VALID, .LMQ_LINE, .LMQ_CONF,
    .L3_VALID, .L3_LINE, .L3_CONF, .L3_TRANSIENT, .MEM_DONE, .MEM_FB_VALID, .MEM_FB_BUSY);
  dsp_mem_model i_mem (.MCLK, .RESET_N, .PIPE_REQ, .LMQ_VALID, .L3_VALID, .hit_mode, .slow,
    .PIPE_GRANT, .PIPE_L1_HIT, .MEM_DONE, .MEM_FB_VALID, .MEM_FB_BUSY);
  // ---------------------------------------------------------------------
  // monitor and tasks
  // ---------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (LMQ_VALID === 1'b1) begin
      n1++;
      lo = (LMQ_LINE < lo) ? LMQ_LINE : lo;
      hi = (LMQ_LINE > hi) ? LMQ_LINE : hi;
    end
    if (L3_VALID === 1'b1) begin
      n3++;
      l3_tr = L3_TRANSIENT;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge MCLK);
    HSEL <= 1'b1; HTRANS <= 2'b10; HWRITE <= w; HADDR <= {24'h0, a};
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0; HTRANS <= 2'b00; HWDATA <= wd;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic acc(input logic [LINE_W-1:0] l, input logic ld);
    @(posedge MCLK);
    ACC_VALID <= 1'b1; ACC_LINE <= l; ACC_IS_LOAD <= ld; ACC_L1_MISS <= 1'b1;
    @(posedge MCLK);
    ACC_VALID <= 1'b0;
    repeat (4) @(posedge MCLK);
  endtask
  task automatic touch(input logic st, input logic [3:0] h, input logic [LINE_W-1:0] l, input logic [15:0] u);
    @(posedge MCLK);
    TOUCH_VALID <= 1'b1; TOUCH_STORE <= st; TOUCH_HINT <= h; TOUCH_LINE <= l; TOUCH_UNITS <= u;
    TOUCH_TRANSIENT <= st;
    @(posedge MCLK);
    TOUCH_VALID <= 1'b0;
  endtask
  task automatic clr;
    @(negedge MCLK);
    n1 = 0; n3 = 0; lo = '1; hi = '0;
  endtask
  task automatic settle;
    repeat (60) @(posedge MCLK);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge MCLK);
    RESET_N <= 1'b1;
    ahb(0, REG_CTRL_OFS, 0); chk("ctrl reset", rd, CTRL_RESET);
    ahb(1, REG_ID_OFS, 0); ahb(0, REG_ID_OFS, 0); chk("id", rd, ID_VALUE);
    ahb(0, 8'h40, 0); chk("unmapped", rd, 32'h0);
    ahb(1, REG_CTRL_OFS, 32'h0000_0101); ahb(0, REG_STATUS_OFS, 0);
    chk("urg conserv", rd[1:0], 2'(ADP_CONSERV));
    ahb(0, REG_FEEDBK_OFS, 0); chk("depth min", rd, 32'(DEPTH_MIN));
    ahb(1, REG_CTRL_OFS, 32'h0000_0139); ahb(0, REG_FEEDBK_OFS, 0); chk("depth max", rd, 32'(DEPTH_MAX));
    ahb(1, REG_CTRL_OFS, 32'h0000_0107); ahb(0, REG_CTRL_OFS, 0); chk("ctrl", rd, 32'h0000_0107);
    $display("test registers done");
    slow <= 1'b1;
    clr; acc(25'h100, 1); acc(25'h101, 0); acc(25'h102, 1); settle;
    chk("up l1", n1 != 0, 1);
    chk("up l3", n3 != 0, 1);
    chk("up ahead", hi > 25'h102, 1);
    $display("test ascending done");
    clr; acc(25'h200, 1); acc(25'h1ff, 1); acc(25'h1fe, 1); settle;
    chk("down dir", n1 != 0 && lo < 25'h1fe, 1);
    $display("test descending done");
    slow <= 1'b0;
    clr; touch(0, TH_SINGLE, 25'h300, 0); settle;
    chk("touch l1 n", n1, 1);
    chk("touch l1 line", lo, 25'h300);
    clr; touch(1, TH_SINGLE, 25'h310, 0); settle;
    chk("touch l3 n", n3, 1);
    chk("touch l3 transient", l3_tr, 1);
    hit_mode <= 1'b1;
    clr; touch(0, TH_SINGLE, 25'h320, 0); settle;
    chk("hit dropped", n1, 0);
    hit_mode <= 1'b0;
    $display("test touch done");
    clr; touch(0, TH_START_A, 25'h400, 16'h3); settle;
    chk("sw units", n1, 3);
    clr; touch(0, TH_START_B, 25'h500, 16'h0); settle;
    chk("sw unlimited", n1, 32'(DEPTH_MIN));
    ahb(0, REG_SWCMD_OFS, 0); chk("sw live", rd[15:8] != 8'h0, 1);
    touch(0, TH_STOP, 25'h500, 0); ahb(0, REG_SWCMD_OFS, 0); chk("sw stop", rd[15:8], 0);
    touch(0, TH_START_B, 25'h600, 16'h0); settle;
    CTX_SWITCH <= 1'b1;
    @(posedge MCLK);
    CTX_SWITCH <= 1'b0;
    ahb(0, REG_SWCMD_OFS, 0); chk("sw ctx", rd[15:8], 0);
    $display("test software streams done");
    test_done;
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    mismatches++;
    test_done;
  end
endmodule
bind dsp_prefetcher dsp_props i_props (.MCLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA,
  .PIPE_REQ, .PIPE_GRANT, .PIPE_LINE, .PIPE_L1_HIT, .LMQ_VALID, .LMQ_LINE, .L3_VALID, .L3_LINE, .MEM_DONE);
